// >>> hw/cpsc_active.sv
// Active configuration bank loaded from the buffered registers on commit
`timescale 1ns/1ps
module cpsc_active
  import cpsc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Configuration carrier
  cpsc_cfg_if.bank cfg
);

  // Active copy; reset leaves PLL off, pre-divider by four, external input routed
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      cfg.act_pll <= RST_PLL;
      cfg.act_cal <= RST_CAL;
      cfg.act_ratio <= RST_RATIO;
      cfg.act_src <= RST_SRC;
    end
    else if (cfg.commit)
    begin
      cfg.act_pll <= cfg.sh_pll;
      cfg.act_cal <= cfg.sh_cal;
      cfg.act_ratio <= cfg.sh_ratio;
      cfg.act_src <= cfg.sh_src;
    end
  end

endmodule

// >>> hw/cpsc_top.sv
// Clock path source configuration: AXI4-Lite registers, routing controls and calibration
//
// Operation
// - Reset holds the PLL in asynchronous power-down via the off code.
// - Reset routes external input through the pre-divider set to divide by four.
// - Pre-divider ratios are 2 to 6; never less than two.
// - Bypass bit clear feeds distribution from pre-divider; set bypasses it.
// - Source bit clear picks external input; set picks on-chip oscillator.
// - Power code zero puts the PLL into normal powered operation.
// - Polarity bit clear is positive detector polarity; set is negative.
// - External input as oscillator powers internal one off, feeds prescaler; the code feeds it only while the PLL power code is on.
// - Calibration starts on a committed set after a committed clear; the code also starts it on the first committed set after reset.
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
module cpsc_top
  import cpsc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // PLL controls
  output logic [1:0] pll_power_ctrl,
  output logic pll_enabled,
  output logic pfd_negative,
  // Input routing
  output logic dist_src_osc,
  output logic dist_from_prediv,
  output logic [2:0] prediv_ratio,
  output logic int_osc_enable,
  output logic ext_to_prescaler,
  // Oscillator calibration
  output logic osc_cal_start,
  output logic osc_cal_busy
);

  // ----------------------------------------------------------------
  // Local signals
  // ----------------------------------------------------------------
  cpsc_cfg_if cfg ();
  logic [ADDR_W-1:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  logic wr_fire;
  logic [9:0] wr_idx;
  logic wr_lane0;
  logic [7:0] sh_pll;
  logic [7:0] sh_cal;
  logic [7:0] sh_ratio;
  logic [7:0] sh_src;
  logic commit;
  logic cal_prev;
  cpsc_cal_e cal_state;
  logic [CAL_CNT_W-1:0] cal_cnt;
  logic [31:0] status_word;

  // Index of an aligned word address
  function automatic logic [9:0] word_idx(input logic [ADDR_W-1:0] addr);
    word_idx = addr[ADDR_W-1:2];
  endfunction

  // True when an index names a register of this block
  function automatic logic is_mapped(input logic [9:0] idx);
    is_mapped = (idx == IDX_PLL) || (idx == IDX_CAL) || (idx == IDX_RATIO) ||
                (idx == IDX_SRC) || (idx == IDX_UPD) || (idx == IDX_STAT);
  endfunction

  // ----------------------------------------------------------------
  // Carrier hookup and active bank
  // ----------------------------------------------------------------
  assign cfg.sh_pll = sh_pll;
  assign cfg.sh_cal = sh_cal;
  assign cfg.sh_ratio = sh_ratio;
  assign cfg.sh_src = sh_src;
  assign cfg.commit = commit;

  cpsc_active u_active (
    .clk_sys (clk_sys),
    .reset (reset),
    .cfg (cfg.bank)
  );

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign wr_idx = word_idx(aw_addr);
  assign wr_lane0 = w_strb[0];

  // Address and data are taken independently, in either order
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      s_axi_awready <= 1'b0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end
    else if (wr_fire)
    begin
      aw_held <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_held && !s_axi_bvalid;
    end
  end

  // Data side holder
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_wready <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end
    else if (wr_fire)
    begin
      w_held <= 1'b0;
    end
    else
    begin
      s_axi_wready <= !w_held && !s_axi_bvalid;
    end
  end

  // Write response once both halves are in
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= is_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Buffered registers
  // ----------------------------------------------------------------
  // Software writes land here and act only after a commit
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      sh_pll <= RST_PLL;
      sh_cal <= RST_CAL;
      sh_ratio <= RST_RATIO;
      sh_src <= RST_SRC;
    end
    else if (wr_fire && wr_lane0)
    begin
      if (wr_idx == IDX_PLL)
        sh_pll <= w_data[7:0];
      if (wr_idx == IDX_CAL)
        sh_cal <= w_data[7:0];
      if (wr_idx == IDX_RATIO)
        sh_ratio <= w_data[7:0];
      if (wr_idx == IDX_SRC)
        sh_src <= w_data[7:0];
    end
  end

  // Update bit: one-cycle commit pulse, then reads back as zero
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      commit <= 1'b0;
    else
      commit <= wr_fire && wr_lane0 && (wr_idx == IDX_UPD) && w_data[UPD_BIT];
  end

  // ----------------------------------------------------------------
  // Oscillator calibration
  // ----------------------------------------------------------------
  // A run needs the active bit to go from clear to set; reset leaves it clear
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      cal_prev <= 1'b0;
    else
      cal_prev <= cfg.act_cal[CAL_BIT];
  end

  // Run timer and start pulse
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      cal_state <= CAL_IDLE;
      cal_cnt <= '0;
      osc_cal_start <= 1'b0;
    end
    else
    begin
      osc_cal_start <= 1'b0;
      unique case (cal_state)
        CAL_IDLE:
        begin
          if (cfg.act_cal[CAL_BIT] && !cal_prev)
          begin
            cal_state <= CAL_RUN;
            cal_cnt <= CAL_CNT_W'(CAL_CYCLES - 1);
            osc_cal_start <= 1'b1;
          end
        end
        CAL_RUN:
        begin
          if (cal_cnt == '0)
            cal_state <= CAL_IDLE;
          else
            cal_cnt <= cal_cnt - 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Routing and PLL outputs
  // ----------------------------------------------------------------
  // Decoded from the active bank, registered onto the pins
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      pll_power_ctrl <= PWR_OFF;
      pll_enabled <= 1'b0;
      pfd_negative <= 1'b0;
      dist_src_osc <= 1'b0;
      dist_from_prediv <= 1'b1;
      prediv_ratio <= cpsc_ratio_of(RST_RATIO[RATIO_MSB:0]);
      int_osc_enable <= 1'b0;
      ext_to_prescaler <= 1'b0;
      osc_cal_busy <= 1'b0;
    end
    else
    begin
      pll_power_ctrl <= cfg.act_pll[PWR_MSB:PWR_LSB];
      pll_enabled <= cfg.act_pll[PWR_MSB:PWR_LSB] == PWR_ON;
      pfd_negative <= cfg.act_pll[PFD_BIT];
      dist_src_osc <= cfg.act_src[SRCSEL_BIT];
      dist_from_prediv <= !cfg.act_src[BYPASS_BIT];
      prediv_ratio <= cpsc_ratio_of(cfg.act_ratio[RATIO_MSB:0]);
      int_osc_enable <= cfg.act_src[SRCSEL_BIT];
      ext_to_prescaler <= !cfg.act_src[SRCSEL_BIT] &&
                          (cfg.act_pll[PWR_MSB:PWR_LSB] == PWR_ON);
      osc_cal_busy <= (cal_state == CAL_RUN) || (cfg.act_cal[CAL_BIT] && !cal_prev);
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  // Status word reflects what is active, not what is buffered
  always_comb
  begin
    status_word = '0;
    status_word[ST_PWR_LSB +: 2] = pll_power_ctrl;
    status_word[ST_PFD] = pfd_negative;
    status_word[ST_SRC] = dist_src_osc;
    status_word[ST_BYPASS] = !dist_from_prediv;
    status_word[ST_RATIO_LSB +: 3] = prediv_ratio;
    status_word[ST_CAL_BUSY] = osc_cal_busy;
    status_word[ST_OSC_EN] = int_osc_enable;
  end

  // Address taken when no answer is pending; data one cycle later
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= is_mapped(word_idx(s_axi_araddr)) ? RESP_OKAY : RESP_SLVERR;
      unique case (word_idx(s_axi_araddr))
        IDX_PLL: s_axi_rdata <= {24'h00_0000, sh_pll};
        IDX_CAL: s_axi_rdata <= {24'h00_0000, sh_cal};
        IDX_RATIO: s_axi_rdata <= {24'h00_0000, sh_ratio};
        IDX_SRC: s_axi_rdata <= {24'h00_0000, sh_src};
        IDX_UPD: s_axi_rdata <= {31'h0000_0000, commit};
        IDX_STAT: s_axi_rdata <= status_word;
        default: s_axi_rdata <= '0;
      endcase
    end
    else if (s_axi_rvalid)
    begin
      if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
    else
    begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// >>> inc/cpsc_cfg_if.sv
// Carrier between the register front end and the active configuration bank
`timescale 1ns/1ps
interface cpsc_cfg_if;
  logic [7:0] sh_pll;
  logic [7:0] sh_cal;
  logic [7:0] sh_ratio;
  logic [7:0] sh_src;
  logic commit;
  logic [7:0] act_pll;
  logic [7:0] act_cal;
  logic [7:0] act_ratio;
  logic [7:0] act_src;

  modport regs (output sh_pll, output sh_cal, output sh_ratio, output sh_src, output commit,
                input act_pll, input act_cal, input act_ratio, input act_src);
  modport bank (input sh_pll, input sh_cal, input sh_ratio, input sh_src, input commit,
                output act_pll, output act_cal, output act_ratio, output act_src);
endinterface

// >>> inc/cpsc_pkg.sv
// Constants, register map and helpers for the clock path source configuration block
package cpsc_pkg;

  // ----------------------------------------------------------------
  // Bus geometry and answers
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_PLL = 10'h010;
  localparam logic [9:0] IDX_CAL = 10'h018;
  localparam logic [9:0] IDX_RATIO = 10'h1e0;
  localparam logic [9:0] IDX_SRC = 10'h1e1;
  localparam logic [9:0] IDX_UPD = 10'h232;
  localparam logic [9:0] IDX_STAT = 10'h240;

  // ----------------------------------------------------------------
  // Reset values of the configuration registers
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_PLL = 8'h01;
  localparam logic [7:0] RST_CAL = 8'h00;
  localparam logic [7:0] RST_RATIO = 8'h02;
  localparam logic [7:0] RST_SRC = 8'h00;

  // ----------------------------------------------------------------
  // Field positions and codes
  // ----------------------------------------------------------------
  localparam int PWR_LSB = 0;
  localparam int PWR_MSB = 1;
  localparam int PFD_BIT = 7;
  localparam int CAL_BIT = 0;
  localparam int RATIO_MSB = 2;
  localparam int BYPASS_BIT = 0;
  localparam int SRCSEL_BIT = 1;
  localparam int UPD_BIT = 0;
  localparam logic [1:0] PWR_ON = 2'h0;
  localparam logic [1:0] PWR_OFF = 2'h1;
  localparam logic [2:0] RATIO_MIN = 3'h2;
  localparam logic [2:0] RATIO_MAX = 3'h6;
  localparam logic [2:0] RATIO_CODE_MAX = 3'h4;

  // ----------------------------------------------------------------
  // Status register layout
  // ----------------------------------------------------------------
  localparam int ST_PWR_LSB = 0;
  localparam int ST_PFD = 2;
  localparam int ST_SRC = 3;
  localparam int ST_BYPASS = 4;
  localparam int ST_RATIO_LSB = 5;
  localparam int ST_CAL_BUSY = 8;
  localparam int ST_OSC_EN = 9;

  // ----------------------------------------------------------------
  // Calibration timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int CAL_TIME_NS = 1000;
  localparam int CAL_CYCLES = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAL_CNT_W = 8;

  // Calibration sequencer states
  typedef enum logic {CAL_IDLE, CAL_RUN} cpsc_cal_e;

  // Divide ratio from the pre-divider code; codes above four clamp to the top ratio
  function automatic logic [2:0] cpsc_ratio_of(input logic [2:0] code);
    logic [3:0] sum;
    sum = {1'b0, code} + {1'b0, RATIO_MIN};
    if (code > RATIO_CODE_MAX)
      cpsc_ratio_of = RATIO_MAX;
    else
      cpsc_ratio_of = sum[2:0];
  endfunction

endpackage

// >>> test/cpsc_ext_src.sv
// Behavioural external clock source in front of the input path
`timescale 1ns/1ps
module cpsc_ext_src
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Routing seen by the source
  input wire logic ext_to_prescaler,
  // Source side
  output logic ext_clk,
  output logic [7:0] pre_edges
);
  // A crystal source runs free, so it toggles whether used or not
  always_ff @(posedge clk_sys)
    ext_clk <= reset ? 1'b0 : !ext_clk;
  // Edges that reach the prescaler while the loop runs on this source
  always_ff @(posedge clk_sys)
    if (reset)
      pre_edges <= 8'h00;
    else if (ext_to_prescaler && ext_clk)
      pre_edges <= pre_edges + 8'h01;
endmodule

// >>> test/cpsc_monitor.sv
// Concurrent checks on the ports of the clock path source configuration block
`timescale 1ns/1ps
module cpsc_monitor
  import cpsc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Routing and PLL outputs
  input wire logic [1:0] pll_power_ctrl,
  input wire logic pll_enabled,
  input wire logic dist_src_osc,
  input wire logic dist_from_prediv,
  input wire logic [2:0] prediv_ratio,
  input wire logic int_osc_enable,
  input wire logic ext_to_prescaler,
  // Calibration
  input wire logic osc_cal_start,
  input wire logic osc_cal_busy
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  // ----------------------------------------------------------------
  // Routing and power
  // ----------------------------------------------------------------
  property p_rst_dflt;
    $past(reset) |-> pll_power_ctrl == PWR_OFF && dist_from_prediv && !dist_src_osc && prediv_ratio == 3'h4;
  endproperty
  a_rst_dflt: assert property (p_rst_dflt) else $error("outputs differ from defaults after reset");
  property p_ratio_rng;
    prediv_ratio >= RATIO_MIN && prediv_ratio <= RATIO_MAX;
  endproperty
  a_ratio_rng: assert property (p_ratio_rng) else $error("pre-divider ratio out of range");
  property p_pll_on;
    pll_enabled == (pll_power_ctrl == PWR_ON);
  endproperty
  a_pll_on: assert property (p_pll_on) else $error("PLL enable disagrees with power code");
  property p_osc_en;
    int_osc_enable == dist_src_osc;
  endproperty
  a_osc_en: assert property (p_osc_en) else $error("oscillator enable disagrees with source");
  property p_ext_pre;
    ext_to_prescaler == (!dist_src_osc && pll_enabled);
  endproperty
  a_ext_pre: assert property (p_ext_pre) else $error("external feed to prescaler wrong");
  // Output moves only two edges after the cycle in which the commit write is answered
  property p_commit;
    $changed(prediv_ratio) |-> $past(s_axi_bvalid, 2) || $past(reset);
  endproperty
  a_commit: assert property (p_commit) else $error("ratio changed without a commit");

  // ----------------------------------------------------------------
  // Calibration and bus answers
  // ----------------------------------------------------------------
  sequence s_cal_go;
    osc_cal_start ##1 !osc_cal_start;
  endsequence
  sequence s_cal_hold;
    osc_cal_busy [*8];
  endsequence
  property p_cal_run;
    s_cal_go |-> s_cal_hold;
  endproperty
  a_cal_run: assert property (p_cal_run) else $error("calibration start not followed by busy");
  property p_cal_end;
    osc_cal_start |-> ##[20:40] !osc_cal_busy;
  endproperty
  a_cal_end: assert property (p_cal_end) else $error("calibration busy too long");
  property p_wr_ans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
  property p_rd_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
endmodule

bind cpsc_top cpsc_monitor mon (.*);

// >>> test/cpsc_top_bench.sv
// Register level tests of the clock path source configuration block
`timescale 1ns/1ps
module cpsc_top_bench;
  import cpsc_pkg::*;
  logic clk_sys, reset;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, pll_power_ctrl;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic pll_enabled, pfd_negative, dist_src_osc, dist_from_prediv, int_osc_enable;
  logic ext_to_prescaler, osc_cal_start, osc_cal_busy, ext_clk;
  logic [2:0] prediv_ratio;
  logic [7:0] pre_edges;
  int err_total, checks, starts;

  cpsc_top DUT (.*);
  cpsc_ext_src ext (.*);

  // ----------------------------------------------------------------
  // Clock, calibration start counter and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
    if (osc_cal_start === 1'b1)
      starts++;
  initial
  begin
    #1_000_000;
    err_total++;
    end_of_test;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk_sys);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1 && n < 200);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
    chk(32'(n < 200), 32'h1);
  endtask
  task automatic rd(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk_sys);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1 && n < 200);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, {24'h00_0000, d});
    chk(32'(s_axi_rresp), 32'(er));
    chk(32'(n < 200), 32'h1);
  endtask
  // Buffered write, commit, then wait until the pins follow
  task automatic cfg(input logic [9:0] idx, input logic [7:0] d);
    wr(idx, d, RESP_OKAY);
    wr(IDX_UPD, 8'h01, RESP_OKAY);
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic done(input string n);
    $display("test %0s finished", n);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    int r;
    logic [7:0] srcs [3];
    srcs = '{8'h01, 8'h02, 8'h00};
    r = 4;
    reset = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hf;
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    chk(32'(pll_power_ctrl), 32'(PWR_OFF));
    chk(32'(pre_edges), 32'h0);
    chk(32'(dist_from_prediv), 32'h1);
    chk(32'(prediv_ratio), 32'h4);
    chk(32'(dist_src_osc), 32'h0);
    rd(IDX_PLL, 8'h01, RESP_OKAY);
    rd(IDX_RATIO, 8'h02, RESP_OKAY);
    rd(IDX_SRC, 8'h00, RESP_OKAY);
    done("defaults");
    // Every ratio code; pins hold until the commit
    for (int c = 0; c < 8; c++)
    begin
      wr(IDX_RATIO, 8'(c), RESP_OKAY);
      chk(32'(prediv_ratio), 32'(r));
      wr(IDX_UPD, 8'h01, RESP_OKAY);
      repeat (3) @(posedge clk_sys);
      r = (c > 4) ? 6 : c + 2;
      chk(32'(prediv_ratio), 32'(r));
    end
    rd(IDX_UPD, 8'h00, RESP_OKAY);
    done("ratio");
    // Pre-divider kept in path whenever the bypass bit is clear, whichever source is chosen
    foreach (srcs[i])
    begin
      cfg(IDX_SRC, srcs[i]);
      chk(32'(dist_from_prediv), 32'(!srcs[i][0]));
      chk(32'(dist_src_osc), 32'(srcs[i][1]));
      chk(32'(int_osc_enable), 32'(srcs[i][1]));
    end
    done("source");
    cfg(IDX_PLL, 8'h80);
    chk(32'(pll_power_ctrl), 32'(PWR_ON));
    chk(32'(pll_enabled), 32'h1);
    chk(32'(pfd_negative), 32'h1);
    chk(32'(ext_to_prescaler), 32'h1);
    // Source is high every other edge, so give it two edges to reach the prescaler
    repeat (2) @(posedge clk_sys);
    chk(32'(pre_edges != 8'h00), 32'h1);
    cfg(IDX_SRC, 8'h02);
    chk(32'(ext_to_prescaler), 32'h0);
    cfg(IDX_SRC, 8'h00);
    cfg(IDX_PLL, 8'h01);
    chk(32'(pll_power_ctrl), 32'(PWR_OFF));
    chk(32'(pfd_negative), 32'h0);
    chk(32'(ext_to_prescaler), 32'h0);
    done("pll");
    // First calibration needs no clear; a repeat set without clear does nothing
    cfg(IDX_CAL, 8'h01);
    repeat (40) @(posedge clk_sys);
    chk(32'(starts), 32'h1);
    chk(32'(osc_cal_busy), 32'h0);
    cfg(IDX_CAL, 8'h01);
    repeat (40) @(posedge clk_sys);
    chk(32'(starts), 32'h1);
    cfg(IDX_CAL, 8'h00);
    cfg(IDX_CAL, 8'h01);
    repeat (40) @(posedge clk_sys);
    chk(32'(starts), 32'h2);
    done("calibration");
    // Status shows the active routing; a write without lane zero changes nothing
    rd(IDX_STAT, 8'hc1, RESP_OKAY);
    s_axi_wstrb <= 4'he;
    wr(IDX_PLL, 8'h80, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(IDX_PLL, 8'h01, RESP_OKAY);
    done("status");
    wr(10'h3ff, 8'h5a, RESP_SLVERR);
    rd(10'h3ff, 8'h00, RESP_SLVERR);
    done("unmapped");
    end_of_test;
  end
endmodule
